// ---- verilog/wcit_pkg.sv ----
/*
  Shared constants and types for the two-wire wiper code target: the fixed
  target address, power-on preset, bit counts, state encoding and the
  structs that carry pins and wiper loads across the clock boundary.
  Assumes it is compiled before every other design file.
*/
package wcit_pkg;

  // wiper code and tap geometry
  localparam int WCIT_CODE_W = 7;
  localparam int WCIT_TAPS = 128;

  // fixed target address, upper seven bits of the address byte
  localparam logic [6:0] WCIT_TARGET_ADDR = 7'h2e;
  // direction bit value that selects a read
  localparam logic WCIT_DIR_READ = 1'b1;

  // power-on midscale preset and its decoded tap
  localparam logic [6:0] WCIT_WIPER_PRESET = 7'h40;
  localparam logic [127:0] WCIT_TAP_PRESET = 128'h1 << WCIT_WIPER_PRESET;

  // read byte msb is always returned as this value
  localparam logic WCIT_READ_MSB = 1'b0;

  // bit counter within a byte
  localparam logic [2:0] WCIT_BIT_FIRST = 3'h0;
  localparam logic [2:0] WCIT_BIT_LAST = 3'h7;
  localparam logic [2:0] WCIT_BIT_STEP = 3'h1;

  // released bus reads high
  localparam logic WCIT_LINE_HIGH = 1'b1;
  localparam logic WCIT_LINE_LOW = 1'b0;

  // bus engine states
  typedef enum logic [2:0] {
    S_IDLE,
    S_ADDR,
    S_ADDR_ACK,
    S_WDATA,
    S_WACK,
    S_RDATA,
    S_RACK
  } wcit_state_t;

  // sampled bus pins
  typedef struct packed {
    logic scl;
    logic sda;
  } wcit_pins_t;

  // wiper load handed from the link domain to the core domain
  typedef struct packed {
    logic tgl;
    logic [WCIT_CODE_W-1:0] code;
  } wcit_load_t;

  localparam wcit_pins_t WCIT_PINS_IDLE = '{scl: 1'b1, sda: 1'b1};
  localparam wcit_load_t WCIT_LOAD_RESET = '{tgl: 1'b0,
                                             code: WCIT_WIPER_PRESET};

endpackage

// ---- verilog/wcit_sync.sv ----
/*
  Two-stage synchroniser for a group of bits into the core clock domain.
  Assumes multi-bit groups are only read when the source holds them still
  for several core cycles, as the wiper load handshake guarantees.
*/
`timescale 1ns/1ps
module wcit_sync import wcit_pkg::*; #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] q_next;

  // first stage feeds only the second stage
  always_comb begin
    meta_next = d;
    q_next = meta_reg;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_reg <= RST_VAL;
      q <= RST_VAL;
    end else if (clk_en) begin
      meta_reg <= meta_next;
      q <= q_next;
    end
  end

endmodule // wcit_sync

// ---- verilog/wcit_target.sv ----
/*
  Two-wire serial target that loads and reads back a 7-bit wiper code and
  decodes it to one of 128 taps. The bus engine runs on the serial clock;
  START/STOP watching and the wiper outputs run on core_clk.
  Assumes the master keeps tBUF between STOP and the next START longer than
  a few core cycles, and that clk_en is high while the bus is in use.
*/
`timescale 1ns/1ps
// Functional notes
// - answer only the fixed seven-bit target address
// - direction bit zero writes, one reads
// - START begins address byte reception
// - matching address acked low on ninth pulse
// - address miss: release SDA, ignore until START
// - write data byte is acked by target
// - SDA changes only while SCL low
// - read byte shifted over eight pulses
// - STOP returns the target to idle
// - every following write byte updates the wiper
// - read repeats while master keeps acknowledging
// - byte msb ignored on write, zero on read
// - wiper presets to midscale at power-on
// - wiper code selects exactly one tap
module wcit_target import wcit_pkg::*; (
  // core clock, reset, enable
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // serial bus
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // wiper position
  output logic [WCIT_CODE_W-1:0] wiper_code,
  output logic [WCIT_TAPS-1:0] tap_sel,
  // bus status
  output logic bus_active
);

  // one-hot tap for a wiper code
  function automatic logic [WCIT_TAPS-1:0] tap_decode(
    input logic [WCIT_CODE_W-1:0] code);
    logic [WCIT_TAPS-1:0] onehot;
    onehot = '0;
    onehot[code] = 1'b1;
    return onehot;
  endfunction

  // byte returned on every read
  function automatic logic [7:0] read_byte(
    input logic [WCIT_CODE_W-1:0] code);
    return {WCIT_READ_MSB, code};
  endfunction

  // link domain state
  wcit_state_t state_reg, state_next;
  logic [2:0] cnt_reg, cnt_next;
  logic [6:0] shift_reg, shift_next;
  logic [7:0] tx_reg, tx_next;
  logic rw_reg, rw_next;
  logic oe_next;
  logic rise_sda_reg;
  logic [WCIT_CODE_W-1:0] latch_reg, latch_next;
  logic tgl_reg, tgl_next;
  logic start_seen;
  logic [7:0] rx_byte;
  logic [7:0] rd_byte;
  logic engine_rst;

  // core domain state
  wcit_pins_t pins_s, pins_prev_reg, pins_prev_next;
  wcit_load_t load_s;
  logic tgl_prev_reg, tgl_prev_next;
  logic load_pend_reg, load_pend_next;
  logic [WCIT_CODE_W-1:0] wiper_next;
  logic [WCIT_TAPS-1:0] tap_next;
  logic bus_active_next;
  logic stop_rst_reg, stop_rst_next;
  logic start_ev, stop_ev;
  logic seen_load_reg;

  // a STOP cannot be seen on the serial clock, so the core clears the engine
  assign engine_rst = sys_rst | stop_rst_reg;

  // data sampled while SCL is high
  always_ff @(posedge scl or posedge engine_rst) begin
    if (engine_rst) begin
      rise_sda_reg <= WCIT_LINE_HIGH; // idle bus, so first fall can be START
    end else begin
      rise_sda_reg <= sda_in;
    end
  end

  // high at the rise, low at the fall: SDA fell while SCL was high
  assign start_seen = rise_sda_reg & ~sda_in;
  assign rx_byte = {shift_reg, rise_sda_reg};
  // a function result cannot be bit-selected, so name the read byte
  assign rd_byte = read_byte(latch_reg);

  // engine next state, evaluated at each SCL fall
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg + WCIT_BIT_STEP;
    shift_next = shift_reg;
    tx_next = tx_reg;
    rw_next = rw_reg;
    oe_next = 1'b0; // released unless a branch drives low
    latch_next = latch_reg;
    tgl_next = tgl_reg;
    if (start_seen) begin
      state_next = S_ADDR;
      cnt_next = WCIT_BIT_FIRST;
    end else begin
      case (state_reg)
        S_ADDR: begin
          shift_next = rx_byte[6:0];
          if (cnt_reg == WCIT_BIT_LAST) begin
            if (rx_byte[7:1] == WCIT_TARGET_ADDR) begin
              oe_next = 1'b1;
              rw_next = rx_byte[0];
              state_next = S_ADDR_ACK;
            end else begin
              state_next = S_IDLE;
            end
          end
        end
        S_ADDR_ACK: begin
          cnt_next = WCIT_BIT_FIRST;
          if (rw_reg == WCIT_DIR_READ) begin
            tx_next = rd_byte << 1;
            oe_next = ~rd_byte[7];
            state_next = S_RDATA;
          end else begin
            state_next = S_WDATA;
          end
        end
        S_WDATA: begin
          shift_next = rx_byte[6:0];
          if (cnt_reg == WCIT_BIT_LAST) begin
            latch_next = rx_byte[WCIT_CODE_W-1:0];
            tgl_next = ~tgl_reg;
            oe_next = 1'b1;
            state_next = S_WACK;
          end
        end
        S_WACK: begin
          cnt_next = WCIT_BIT_FIRST;
          state_next = S_WDATA;
        end
        S_RDATA: begin
          if (cnt_reg == WCIT_BIT_LAST) begin
            state_next = S_RACK; // ninth clock belongs to the master
          end else begin
            oe_next = ~tx_reg[7];
            tx_next = tx_reg << 1;
          end
        end
        S_RACK: begin
          cnt_next = WCIT_BIT_FIRST;
          if (rise_sda_reg == WCIT_LINE_LOW) begin
            tx_next = rd_byte << 1;
            oe_next = ~rd_byte[7];
            state_next = S_RDATA;
          end else begin
            state_next = S_IDLE;
          end
        end
        default: begin
          cnt_next = cnt_reg; // idle: traffic ignored until START
        end
      endcase
    end
  end

  // drive changes only at the fall, so SDA is steady while SCL is high
  always_ff @(negedge scl or posedge engine_rst) begin
    if (engine_rst) begin
      state_reg <= S_IDLE;
      cnt_reg <= WCIT_BIT_FIRST;
      shift_reg <= '0;
      tx_reg <= '0;
      rw_reg <= 1'b0;
      sda_oe <= 1'b0;
      sda_out <= WCIT_LINE_LOW;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      tx_reg <= tx_next;
      rw_reg <= rw_next;
      sda_oe <= oe_next;
      sda_out <= WCIT_LINE_LOW; // open drain: only ever pulls low
    end
  end

  // wiper latch survives STOP; only power-on reset presets it
  always_ff @(negedge scl or posedge sys_rst) begin
    if (sys_rst) begin
      latch_reg <= WCIT_WIPER_PRESET;
      tgl_reg <= 1'b0;
    end else begin
      latch_reg <= latch_next;
      tgl_reg <= tgl_next;
    end
  end

  // bus pins into the core domain
  wcit_sync #(.WIDTH(2), .RST_VAL(WCIT_PINS_IDLE)) u_pin_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .d({scl, sda_in}),
    .q(pins_s)
  );

  // wiper load: toggle and code held steady for a whole byte
  wcit_sync #(.WIDTH(WCIT_CODE_W + 1), .RST_VAL(WCIT_LOAD_RESET)) u_ld_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .d({tgl_reg, latch_reg}),
    .q(load_s)
  );

  // core side: START/STOP watch and wiper outputs
  always_comb begin
    start_ev = pins_s.scl & pins_prev_reg.scl & pins_prev_reg.sda
               & ~pins_s.sda;
    stop_ev = pins_s.scl & pins_prev_reg.scl & ~pins_prev_reg.sda
              & pins_s.sda;
    pins_prev_next = pins_s;
    stop_rst_next = stop_ev;
    bus_active_next = bus_active;
    if (start_ev) begin
      bus_active_next = 1'b1;
    end else if (stop_ev) begin
      bus_active_next = 1'b0;
    end
    tgl_prev_next = load_s.tgl;
    // take the code one cycle after the toggle edge so it has settled
    load_pend_next = load_s.tgl ^ tgl_prev_reg;
    wiper_next = wiper_code;
    tap_next = tap_sel;
    if (load_pend_reg) begin
      wiper_next = load_s.code;
      tap_next = tap_decode(load_s.code);
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pins_prev_reg <= WCIT_PINS_IDLE;
      stop_rst_reg <= 1'b0;
      bus_active <= 1'b0;
      tgl_prev_reg <= 1'b0;
      load_pend_reg <= 1'b0;
      wiper_code <= WCIT_WIPER_PRESET;
      tap_sel <= WCIT_TAP_PRESET;
    end else if (clk_en) begin
      pins_prev_reg <= pins_prev_next;
      stop_rst_reg <= stop_rst_next;
      bus_active <= bus_active_next;
      tgl_prev_reg <= tgl_prev_next;
      load_pend_reg <= load_pend_next;
      wiper_code <= wiper_next;
      tap_sel <= tap_next;
    end
  end

  // helper for the preset check
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      seen_load_reg <= 1'b0;
    end else if (clk_en && load_pend_reg) begin
      seen_load_reg <= 1'b1;
    end
  end

  // link domain checks
  chk_start_addr: assert property (
    @(negedge scl) disable iff (engine_rst)
    start_seen |=> state_reg == S_ADDR && cnt_reg == WCIT_BIT_FIRST
  ) else $error("START did not begin address reception");

  chk_addr_ack: assert property (
    @(negedge scl) disable iff (engine_rst)
    (state_reg == S_ADDR && cnt_reg == WCIT_BIT_LAST && !start_seen
     && rx_byte[7:1] == WCIT_TARGET_ADDR)
    |=> sda_oe && state_reg == S_ADDR_ACK
  ) else $error("matching address not acknowledged");

  chk_addr_miss: assert property (
    @(negedge scl) disable iff (engine_rst)
    (state_reg == S_ADDR && cnt_reg == WCIT_BIT_LAST && !start_seen
     && rx_byte[7:1] != WCIT_TARGET_ADDR)
    |=> !sda_oe && state_reg == S_IDLE
  ) else $error("address miss did not release the bus");

  chk_dir_select: assert property (
    @(negedge scl) disable iff (engine_rst)
    (state_reg == S_ADDR_ACK && !start_seen)
    |=> state_reg == (rw_reg ? S_RDATA : S_WDATA)
  ) else $error("direction bit chose the wrong transfer");

  chk_write_load: assert property (
    @(negedge scl) disable iff (engine_rst)
    (state_reg == S_WDATA && cnt_reg == WCIT_BIT_LAST && !start_seen)
    |=> latch_reg == $past(rx_byte[6:0]) && sda_oe
        && tgl_reg != $past(tgl_reg)
  ) else $error("write byte not loaded at its ack clock");

  chk_ack_release: assert property (
    @(negedge scl) disable iff (engine_rst)
    (state_reg == S_WACK && !start_seen) |=> !sda_oe ##1 !sda_oe[*1]
      or state_reg == S_ADDR
  ) else $error("write ack held beyond its clock");

  chk_read_msb: assert property (
    @(negedge scl) disable iff (engine_rst)
    (state_reg == S_RDATA && cnt_reg == WCIT_BIT_FIRST) |-> sda_oe
  ) else $error("read byte msb not driven as zero");

  chk_read_nack: assert property (
    @(negedge scl) disable iff (engine_rst)
    (state_reg == S_RACK && !start_seen)
    |-> (rise_sda_reg ? state_next == S_IDLE && !oe_next
                      : state_next == S_RDATA && tx_next == rd_byte << 1)
  ) else $error("read continuation after master ack is wrong");

  // core domain checks
  chk_stop_idle: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (stop_ev && clk_en) |=> !bus_active && stop_rst_reg
  ) else $error("STOP did not return the bus to idle");

  chk_tap_onehot: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    $onehot(tap_sel) && tap_sel == tap_decode(wiper_code)
  ) else $error("tap select does not match wiper code");

  chk_preset_hold: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !seen_load_reg |-> wiper_code == WCIT_WIPER_PRESET
  ) else $error("wiper left midscale before any load");

  // main scenarios
  cov_write_load: cover property (
    @(negedge scl) disable iff (engine_rst) state_reg == S_WACK);
  cov_repeat_write: cover property (
    @(negedge scl) disable iff (engine_rst)
    state_reg == S_WACK ##9 state_reg == S_WACK);
  cov_read_nack: cover property (
    @(negedge scl) disable iff (engine_rst)
    state_reg == S_RACK && rise_sda_reg ##1 state_reg == S_IDLE);
  cov_addr_miss: cover property (
    @(negedge scl) disable iff (engine_rst)
    state_reg == S_ADDR ##1 state_reg == S_IDLE);

endmodule // wcit_target

// ---- verif/wcit_bus_master.sv ----
/*
  Behavioural two-wire bus master for the wiper code target bench.
  Assumes a pull-up on SDA: sda_drv high releases the line, low pulls it.
  SCL runs at 64 ns only inside frames and stands high between them.
*/
`timescale 1ns/1ps
module wcit_bus_master (
  // bus lines
  output logic scl,
  output logic sda_drv,
  input wire logic sda_line
);
  // idle bus: both lines released high
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // one bit: SDA moves only while SCL is low, sampled mid high phase
  task automatic bit_io(input logic b, output logic s);
    sda_drv = b;
    #16 scl = 1'b1;
    #16 s = sda_line;
    #16 scl = 1'b0;
    #16;
  endtask

  // eight bits msb first, then the ninth pulse driven with mack
  task automatic byte_io(input logic [7:0] tx, input logic mack,
      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(mack, ack);
  endtask

  // START or repeated START: SDA falls while SCL is high
  task automatic start();
    sda_drv = 1'b1;
    #16 scl = 1'b1;
    #32 sda_drv = 1'b0;
    #32 scl = 1'b0;
    #16;
  endtask

  // STOP: SDA low before the pulse, rises while SCL is high
  task automatic stop();
    sda_drv = 1'b0;
    #16 scl = 1'b1;
    #32 sda_drv = 1'b1;
    #100; // bus free time before any next START
  endtask
endmodule // wcit_bus_master

// ---- verif/wiper_code_i2c_target_test.sv ----
/*
  Self-checking bench for the wiper code target: reads, repeated writes,
  repeated START, address misses and resets, with xorshift stimulus.
  Assumes the bus master model drives SCL and SDA, resolved open drain.
*/
`timescale 1ns/1ps
module wiper_code_i2c_target_test;
  import wcit_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b0;
  logic clk_en = 1'b1;
  logic scl;
  logic sda_drv;
  logic sda_in;
  logic sda_out;
  logic sda_oe;
  logic bus_active;
  logic [WCIT_CODE_W-1:0] wiper_code;
  logic [WCIT_TAPS-1:0] tap_sel;
  int miscompares = 0;
  int compares = 0;
  logic [31:0] seed = 32'h35;
  logic [31:0] r;
  logic [7:0] rx;
  logic [7:0] wb;
  logic [6:0] code;
  logic ack;

  always #5 core_clk = ~core_clk;

  // wire is low if either party pulls it, else the pull-up wins
  assign sda_in = ~((sda_oe & ~sda_out) | ~sda_drv);

  wcit_target dut (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .scl(scl),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .wiper_code(wiper_code),
    .tap_sel(tap_sel),
    .bus_active(bus_active)
  );

  wcit_bus_master m (
    .scl(scl),
    .sda_drv(sda_drv),
    .sda_line(sda_in)
  );

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input string what, input logic [127:0] exp,
      input logic [127:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // code and its one-hot tap, worked out here
  task automatic chk_wiper(input logic [6:0] c);
    chk("wiper_code", {121'h0, c}, {121'h0, wiper_code});
    chk("tap_sel", 128'h1 << c, tap_sel);
  endtask

  // bounded wait for the core side to see the STOP
  task automatic wait_idle();
    int n;
    n = 0;
    while (bus_active !== 1'b0 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    chk("bus_active after stop", 128'h0, {127'h0, bus_active});
    if (n == 20) begin
      complete_run();
    end
  endtask

  // hang guard, far beyond the roughly ten microseconds needed
  initial begin
    #900000;
    miscompares++;
    complete_run();
  end

  initial begin
    // a real rising edge, so the async resets of every domain fire
    #1;
    sys_rst = 1'b1;
    repeat (10) @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (3) @(negedge core_clk);
    chk_wiper(WCIT_WIPER_PRESET);
    chk("sda_oe idle", 128'h0, {127'h0, sda_oe});
    // read the preset twice in one transfer, master acks the first
    m.start();
    m.byte_io({WCIT_TARGET_ADDR, 1'b1}, 1'b1, rx, ack);
    chk("read addr ack", 128'h0, {127'h0, ack});
    chk("bus_active", 128'h1, {127'h0, bus_active});
    m.byte_io(8'hff, 1'b0, rx, ack);
    chk("read byte", {120'h0, 1'b0, WCIT_WIPER_PRESET}, {120'h0, rx});
    m.byte_io(8'hff, 1'b1, rx, ack);
    chk("repeat read", {120'h0, 1'b0, WCIT_WIPER_PRESET}, {120'h0, rx});
    m.stop();
    wait_idle();
    // repeated writes after one address, corners first then random
    m.start();
    m.byte_io({WCIT_TARGET_ADDR, 1'b0}, 1'b1, rx, ack);
    chk("write addr ack", 128'h0, {127'h0, ack});
    for (int i = 0; i < 8; i++) begin
      r = xs();
      wb = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : r[7:0];
      m.byte_io(wb, 1'b1, rx, ack);
      chk("data ack", 128'h0, {127'h0, ack});
      chk_wiper(wb[6:0]);
    end
    // direction change by repeated START without STOP
    code = wb[6:0];
    m.start();
    m.byte_io({WCIT_TARGET_ADDR, 1'b1}, 1'b1, rx, ack);
    chk("reread addr ack", 128'h0, {127'h0, ack});
    m.byte_io(8'hff, 1'b1, rx, ack);
    chk("reread byte", {120'h0, 1'b0, code}, {120'h0, rx});
    m.stop();
    wait_idle();
    // foreign address, then a byte that looks like ours: both ignored
    r = xs();
    code = r[6:0];
    if (code == WCIT_TARGET_ADDR) begin
      code = code ^ 7'h01;
    end
    m.start();
    m.byte_io({code, r[7]}, 1'b1, rx, ack);
    chk("miss ack", 128'h1, {127'h0, ack});
    m.byte_io({WCIT_TARGET_ADDR, 1'b0}, 1'b1, rx, ack);
    chk("ignored byte ack", 128'h1, {127'h0, ack});
    chk_wiper(wb[6:0]);
    m.stop();
    wait_idle();
    // mid-run reset brings back midscale
    @(negedge core_clk);
    sys_rst = 1'b1;
    repeat (2) @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (3) @(negedge core_clk);
    chk_wiper(WCIT_WIPER_PRESET);
    complete_run();
  end
endmodule // wiper_code_i2c_target_test
